/* File: rtl/burner_safety_pkg.sv */
// Package: timing constants, states and carrier structs for the burner safety sequencer
package burner_safety_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;
  // Prescaler gives one tick per 1 ms
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned POST_PURGE_S = 30;
  localparam int unsigned AIR_WAIT_MIN = 5;
  localparam int unsigned AIR_LOCK_MIN = 15;
  localparam int unsigned FLAME_LOCK_HOUR = 1;
  localparam int unsigned POST_PURGE_TICKS = POST_PURGE_S * 1000 / TICK_MS;
  localparam int unsigned AIR_WAIT_TICKS = AIR_WAIT_MIN * 60 * 1000 / TICK_MS;
  localparam int unsigned AIR_LOCK_TICKS = AIR_LOCK_MIN * 60 * 1000 / TICK_MS;
  localparam int unsigned FLAME_LOCK_TICKS = FLAME_LOCK_HOUR * 3600 * 1000 / TICK_MS;
  localparam int unsigned RELIGHT_TRIES = 3;
  // Blink half period in ticks
  localparam int unsigned BLINK_TICKS = 500;
  localparam int unsigned TIMER_W = 32;

  typedef enum logic [1:0] {
    LAMP_OFF = 2'h0,
    LAMP_ON = 2'h1,
    LAMP_BLINK = 2'h2
  } lamp_mode_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_LIGHT = 9'h002,
    ST_FIRE = 9'h004,
    ST_PURGE_TRIP = 9'h008,
    ST_PURGE_FLAME = 9'h010,
    ST_PURGE_AIR = 9'h020,
    ST_AIR_WAIT = 9'h040,
    ST_LOCK_FLAME = 9'h080,
    ST_LOCK_AIR = 9'h100
  } seq_state_t;

  typedef struct packed {
    logic heat_call;
    logic service_on;
    logic inducer_temp_ok;
    logic flame_seen;
    logic airflow_ok;
    logic high_limit_ok;
    logic ignition_done;
  } safety_in_t;

  typedef struct packed {
    logic gas_valve;
    logic inducer;
    logic circulator;
    logic lamp_valve;
    logic lamp_flame;
    logic lamp_purge;
    logic light_off_start;
  } actuator_out_t;

endpackage

/* File: rtl/burner_safety_sequencer.sv */
// Burner safety sequencer: trips, post purge, relight, lockouts and auto reset
`timescale 1ns/1ps
module burner_safety_sequencer
  import burner_safety_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned PURGE_LEN = POST_PURGE_TICKS,
  parameter int unsigned AIR_WAIT_LEN = AIR_WAIT_TICKS,
  parameter int unsigned AIR_LOCK_LEN = AIR_LOCK_TICKS,
  parameter int unsigned FLAME_LOCK_LEN = FLAME_LOCK_TICKS,
  parameter int unsigned BLINK_LEN = BLINK_TICKS,
  parameter int unsigned TRIES = RELIGHT_TRIES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire safety_in_t sense,
  output actuator_out_t drive,
  output logic [1:0] lockout_code
);

  // ==========================================================
  // Input synchronisers
  safety_in_t sync_a;
  safety_in_t sync_b;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= sense;
      sync_b <= sync_a;
    end
  end

  wire logic enabled = sync_b.heat_call & sync_b.service_on;
  wire logic limits_ok = sync_b.inducer_temp_ok & sync_b.high_limit_ok;

  // Enable edge: removal of call or service clears lockout
  logic enabled_d;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enabled_d <= 1'b0;
    end else begin
      enabled_d <= enabled;
    end
  end
  wire logic enable_drop = enabled_d & ~enabled;

  // ==========================================================
  // Prescaler and tick timer
  logic [TIMER_W-1:0] pre_cnt;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] blink_cnt;
  logic blink;
  wire logic tick = (pre_cnt == TIMER_W'(TICK_LEN - 1));
  wire logic [TIMER_W-1:0] next_pre_cnt = tick ? '0 : pre_cnt + 1'b1;

  function automatic logic elapsed(input logic [TIMER_W-1:0] t, input int unsigned len);
    elapsed = (t >= TIMER_W'(len));
  endfunction

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt <= '0;
      blink_cnt <= '0;
      blink <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      if (tick) begin
        if (elapsed(blink_cnt, BLINK_LEN - 1)) begin
          blink_cnt <= '0;
          blink <= ~blink;
        end else begin
          blink_cnt <= blink_cnt + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Sequencer
  seq_state_t state;
  seq_state_t next_state;
  logic [1:0] tries;
  logic [1:0] next_tries;
  logic flame_proven;
  logic restart_timer;

  wire logic purge_done = elapsed(timer, PURGE_LEN);
  wire logic firing_fault = ~limits_ok | ~sync_b.airflow_ok | ~sync_b.flame_seen;

  always_comb begin
    next_state = state;
    next_tries = tries;
    restart_timer = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_tries = '0;
        if (enabled && limits_ok) begin
          next_state = ST_LIGHT;
          restart_timer = 1'b1;
        end
      end
      ST_LIGHT: begin
        if (!enabled || !limits_ok) begin
          next_state = ST_PURGE_TRIP;
          restart_timer = 1'b1;
        end else if (sync_b.ignition_done && sync_b.flame_seen) begin
          next_state = ST_FIRE;
          next_tries = '0;
        end else if (sync_b.ignition_done) begin
          next_state = ST_PURGE_FLAME;
          restart_timer = 1'b1;
        end
      end
      ST_FIRE: begin
        if (!enabled || !limits_ok) begin
          next_state = ST_PURGE_TRIP;
          restart_timer = 1'b1;
        end else if (!sync_b.airflow_ok) begin
          next_state = ST_PURGE_AIR;
          restart_timer = 1'b1;
        end else if (!sync_b.flame_seen) begin
          next_state = ST_PURGE_FLAME;
          restart_timer = 1'b1;
        end
      end
      ST_PURGE_TRIP: begin
        if (purge_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_PURGE_FLAME: begin
        if (purge_done) begin
          restart_timer = 1'b1;
          if (!enabled) begin
            next_state = ST_IDLE;
          end else if (tries == 2'(TRIES)) begin
            next_state = ST_LOCK_FLAME;
          end else begin
            next_tries = tries + 2'h1;
            next_state = ST_LIGHT;
          end
        end
      end
      ST_PURGE_AIR: begin
        if (purge_done) begin
          restart_timer = 1'b1;
          next_state = enabled ? ST_AIR_WAIT : ST_IDLE;
        end
      end
      ST_AIR_WAIT: begin
        if (!enabled) begin
          next_state = ST_IDLE;
        end else if (sync_b.airflow_ok && limits_ok) begin
          next_state = ST_LIGHT;
          restart_timer = 1'b1;
        end else if (elapsed(timer, AIR_WAIT_LEN)) begin
          next_state = ST_LOCK_AIR;
          restart_timer = 1'b1;
        end
      end
      ST_LOCK_FLAME: begin
        if (enable_drop || elapsed(timer, FLAME_LOCK_LEN)) begin
          next_state = ST_IDLE;
        end
      end
      ST_LOCK_AIR: begin
        if (enable_drop || elapsed(timer, AIR_LOCK_LEN)) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      tries <= '0;
      timer <= '0;
      flame_proven <= 1'b0;
    end else begin
      state <= next_state;
      tries <= next_tries;
      if (restart_timer) begin
        timer <= '0;
      end else if (tick && !(&timer)) begin
        timer <= timer + 1'b1;
      end
      flame_proven <= (next_state == ST_FIRE);
    end
  end

  // ==========================================================
  // Output decode
  function automatic logic lamp(input lamp_mode_t m, input logic b);
    lamp = (m == LAMP_ON) | ((m == LAMP_BLINK) & b);
  endfunction

  wire logic in_light = (next_state == ST_LIGHT);
  wire logic in_fire = (next_state == ST_FIRE);
  // Valve is cut the same cycle a fault is seen, on the same edge as the state update
  wire logic fault_now = firing_fault | ~enabled;
  wire logic valve_on = (in_light | in_fire) & ~(in_fire & fault_now);
  wire logic inducer_on = in_light | in_fire | (next_state == ST_PURGE_TRIP) |
                          (next_state == ST_PURGE_FLAME) | (next_state == ST_PURGE_AIR);
  wire lamp_mode_t valve_mode = (next_state == ST_LOCK_FLAME) ? LAMP_BLINK :
                                valve_on ? LAMP_ON : LAMP_OFF;
  wire lamp_mode_t purge_mode = (next_state == ST_LOCK_AIR) ? LAMP_BLINK :
                                (inducer_on & sync_b.airflow_ok & ~in_fire) ? LAMP_ON : LAMP_OFF;
  wire lamp_mode_t flame_mode = (in_fire & valve_on) ? LAMP_ON : LAMP_OFF;
  wire logic [1:0] next_code = (next_state == ST_LOCK_FLAME) ? 2'h1 :
                               (next_state == ST_LOCK_AIR) ? 2'h2 : 2'h0;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive <= '0;
      lockout_code <= '0;
    end else begin
      drive.gas_valve <= valve_on;
      drive.inducer <= inducer_on;
      drive.circulator <= sync_b.heat_call;
      drive.lamp_valve <= lamp(valve_mode, blink);
      drive.lamp_flame <= lamp(flame_mode, blink);
      drive.lamp_purge <= lamp(purge_mode, blink);
      drive.light_off_start <= in_light & (state != ST_LIGHT);
      lockout_code <= next_code;
    end
  end

endmodule

/* File: verif/burner_chk.sv */
// Checker of burner sequencer port behaviour
`timescale 1ns/1ps
module burner_chk
  import burner_safety_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire safety_in_t sense,
  input wire actuator_out_t drive,
  input wire logic [1:0] lockout_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ====================
  // Trips and lamps
  property p_ind; $fell(sense.inducer_temp_ok) |-> ##4 !drive.gas_valve && !drive.lamp_valve; endproperty
  a_ind: assert property (p_ind) else $error("inducer trip");
  property p_lim; $fell(sense.high_limit_ok) |-> ##4 !drive.gas_valve && !drive.lamp_flame; endproperty
  a_lim: assert property (p_lim) else $error("limit trip");
  property p_fl; drive.lamp_flame |-> drive.gas_valve; endproperty
  a_fl: assert property (p_fl) else $error("flame lamp");
  property p_purge; $fell(drive.gas_valve) && drive.inducer |=> drive.inducer [*8]; endproperty
  a_purge: assert property (p_purge) else $error("purge short");
  property p_circ; sense.heat_call [*5] |-> drive.circulator; endproperty
  a_circ: assert property (p_circ) else $error("circulator");
  // ====================
  // Lockouts
  property p_lkv; lockout_code != 2'h0 |-> !drive.gas_valve && !drive.lamp_flame; endproperty
  a_lkv: assert property (p_lkv) else $error("valve in lockout");
  property p_bl1; $rose(lockout_code == 2'h1) |-> ##[1:8] $changed(drive.lamp_valve); endproperty
  a_bl1: assert property (p_bl1) else $error("valve blink");
  property p_bl2; $rose(lockout_code == 2'h2) |-> ##[1:8] $changed(drive.lamp_purge); endproperty
  a_bl2: assert property (p_bl2) else $error("purge blink");
  property p_fto;
    $rose(lockout_code == 2'h1) |-> (lockout_code == 2'h1) [*8] ##[1:40] lockout_code == 2'h0;
  endproperty
  a_fto: assert property (p_fto) else $error("flame lockout time");
  property p_clr;
    $fell(sense.heat_call && sense.service_on) && lockout_code != 2'h0 |-> ##[1:5] lockout_code == 2'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("lockout clear");
  c_lk1: cover property (lockout_code == 2'h1);
  c_lk2: cover property (lockout_code == 2'h2);
  c_go: cover property (drive.light_off_start);
endmodule
bind burner_safety_sequencer burner_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .sense(sense),
  .drive(drive), .lockout_code(lockout_code));

/* File: verif/burner_plant.sv */
// Burner plant model: flame and trial end
`timescale 1ns/1ps
module burner_plant
  import burner_safety_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire actuator_out_t drive,
  input wire logic flame_good,
  output logic flame_seen,
  output logic ignition_done
);
  logic [3:0] trial;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trial <= 4'h0;
      flame_seen <= 1'b0;
      ignition_done <= 1'b0;
    end else begin
      // Flame burns only on an open valve
      flame_seen <= drive.gas_valve & flame_good;
      trial <= drive.light_off_start ? 4'h1 : ((trial != 4'h0) ? trial + 4'h1 : 4'h0);
      ignition_done <= (trial == 4'h6);
    end
  end
endmodule

/* File: verif/test_burner_safety_sequencer.sv */
// Testbench of the burner safety sequencer
`timescale 1ns/1ps
module test_burner_safety_sequencer;
  import burner_safety_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic heat = 1'b0, svc = 1'b0, ind_ok = 1'b1, air_ok = 1'b1, lim_ok = 1'b1, flame_good = 1'b1;
  logic flame_seen, ign_done;
  safety_in_t sense;
  actuator_out_t drive;
  logic [1:0] lockout_code;
  int err_count = 0, checks_done = 0, starts = 0, cycles = 0, n;
  assign sense = '{heat, svc, ind_ok, flame_seen, air_ok, lim_ok, ign_done};
  logic v;
  burner_safety_sequencer #(.TICK_LEN(2), .PURGE_LEN(5), .AIR_WAIT_LEN(8),
    .FLAME_LOCK_LEN(12), .BLINK_LEN(1)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sense(sense), .drive(drive), .lockout_code(lockout_code));
  burner_plant u_plant (.sys_clk(sys_clk), .sys_rst(sys_rst), .drive(drive), .flame_good(flame_good),
    .flame_seen(flame_seen), .ignition_done(ign_done));
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (drive.light_off_start === 1'b1) starts <= starts + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ====================
  // Helpers
  task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic wait_lock(input logic [1:0] code);
    n = 0;
    while (lockout_code !== code && n < 400) begin
      tick(1);
      n++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_fire();
    heat = 1'b1;
    svc = 1'b1;
    tick(30);
    check("valve", 1, drive.gas_valve);
    check("flame lamp", 1, drive.lamp_flame);
    check("circ", 1, drive.circulator);
    $display("test fire done");
  endtask
  task automatic t_trip(input int which);
    if (which == 0) ind_ok = 1'b0;
    else lim_ok = 1'b0;
    tick(5);
    check("valve", 0, drive.gas_valve);
    check("valve lamp", 0, drive.lamp_valve);
    check("flame lamp", 0, drive.lamp_flame);
    check("inducer", 1, drive.inducer);
    tick(30);
    check("inducer", 0, drive.inducer);
    check("circ", 1, drive.circulator);
    starts = 0;
    ind_ok = 1'b1;
    lim_ok = 1'b1;
    tick(30);
    check("relight", 1, drive.gas_valve);
    check("starts", 1, starts == 1);
    $display("test trip %0d done", which);
  endtask
  task automatic t_flame();
    flame_good = 1'b0;
    starts = 0;
    tick(5);
    check("valve", 0, drive.gas_valve);
    check("flame lamp", 0, drive.lamp_flame);
    wait_lock(2'h1);
    check("lockout", 1, lockout_code);
    check("tries", 1, starts == 3);
    v = drive.lamp_valve;
    tick(2);
    check("valve blink", {1'b0, ~v}, drive.lamp_valve);
    check("circ", 1, drive.circulator);
    flame_good = 1'b1;
    wait_lock(2'h0);
    check("auto clear", 1, n >= 20 && n <= 40);
    tick(30);
    $display("test flame done");
  endtask
  task automatic t_air();
    air_ok = 1'b0;
    tick(5);
    check("valve", 0, drive.gas_valve);
    check("inducer", 1, drive.inducer);
    wait_lock(2'h2);
    check("air wait", 1, n >= 22 && n <= 40);
    v = drive.lamp_purge;
    tick(2);
    check("purge blink", {1'b0, ~v}, drive.lamp_purge);
    check("circ", 1, drive.circulator);
    svc = 1'b0;
    tick(6);
    check("clear", 0, lockout_code);
    svc = 1'b1;
    air_ok = 1'b1;
    tick(30);
    check("refire", 1, drive.gas_valve);
    $display("test air done");
  endtask
  initial begin
    tick(16);
    sys_rst = 1'b0;
    t_fire();
    t_trip(0);
    t_trip(1);
    t_flame();
    t_air();
    report_and_stop();
  end
endmodule
